// >>> inc/ssb_pkg.sv
// Package with register map, field layout and reset values for the serial status block.
package ssb_pkg;

  // ==========================================================================
  // Register byte addresses.
  localparam logic [11:0] ADDR_STATUS = 12'h000;
  localparam logic [11:0] ADDR_DATA   = 12'h004;
  localparam logic [11:0] ADDR_RATE   = 12'h008;
  localparam logic [11:0] ADDR_CTRL   = 12'h00C;
  localparam logic [11:0] ADDR_PORT   = 12'h010;

  // ==========================================================================
  // Status register bit positions; bit 0 reads as zero.
  localparam int BIT_TXE  = 7;
  localparam int BIT_TXC  = 6;
  localparam int BIT_RXF  = 5;
  localparam int BIT_IDL  = 4;
  localparam int BIT_OVR  = 3;
  localparam int BIT_NSE  = 2;
  localparam int BIT_FRM  = 1;

  // ==========================================================================
  // Rate register layout and reset value (fastest prescaler).
  localparam int          RATE_PRE_LO   = 4;
  localparam int          RATE_PRE_HI   = 6;
  localparam int          RATE_DIV_LO   = 0;
  localparam logic [7:0]  RATE_RESET    = 8'h00;

  // ==========================================================================
  // Control register layout.
  localparam int BIT_TX_EN  = 0;
  localparam int BIT_RX_EN  = 1;
  localparam int BIT_WAKEUP = 2;
  localparam int BIT_BREAK  = 3;
  localparam logic [7:0]  CTRL_RESET    = 8'h00;

  // ==========================================================================
  // Port direction reset value: all shared pins inputs.
  localparam logic [5:0]  PORT_DIR_RESET = 6'h00;

  // Oversampling ratio per bit and idle length in bit times.
  localparam int          OVERSAMPLE    = 16;
  localparam int          IDLE_BITS     = 10;
  localparam int          FRAME_BITS    = 10;

endpackage : ssb_pkg

// >>> inc/ssb_tick_if.sv
// Interface carrying the baud ticks from the rate generator to the serial logic.
`timescale 1ns/1ps
interface ssb_tick_if;
  logic       tick16;
  logic [7:0] rate;

  modport gen (input rate, output tick16);
  modport use_side (output rate, input tick16);
endinterface : ssb_tick_if

// >>> hdl/ssb_rate_gen.sv
// Rate generator: prescaler followed by a power-of-two divider.
`timescale 1ns/1ps
module ssb_rate_gen (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst,
  // Tick carrier
  ssb_tick_if.gen   tk
);

  logic [3:0]  pre_cnt_r;
  logic [7:0]  div_cnt_r;
  logic [3:0]  pre_max;
  logic [7:0]  div_max;
  logic        pre_tick;
  logic        tick_r;

  // Prescale ratio 1, 3, 4 or 13 from the low prescaler bits; high bit selects divide by 16.
  always_comb begin
    unique case (tk.rate[ssb_pkg::RATE_PRE_HI -: 3])
      3'b000:  pre_max = 4'h0;
      3'b001:  pre_max = 4'h2;
      3'b010:  pre_max = 4'h3;
      3'b011:  pre_max = 4'hC;
      default: pre_max = 4'hF;    // High bit set; low bits expected zero.
    endcase
    div_max = 8'((8'h01 << tk.rate[ssb_pkg::RATE_DIV_LO +: 3]) - 8'h01);
  end

  assign pre_tick = (pre_cnt_r >= pre_max);

  // Prescaler counter feeds the divider stage.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pre_cnt_r <= 4'h0;
    end else if (pre_tick) begin
      pre_cnt_r <= 4'h0;
    end else begin
      pre_cnt_r <= pre_cnt_r + 4'h1;
    end
  end

  // Divider counter selected by the rate divider field.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      div_cnt_r <= 8'h00;
      tick_r    <= 1'b0;
    end else begin
      tick_r <= 1'b0;
      if (pre_tick) begin
        if (div_cnt_r >= div_max) begin
          div_cnt_r <= 8'h00;
          tick_r    <= 1'b1;
        end else begin
          div_cnt_r <= div_cnt_r + 8'h01;
        end
      end
    end
  end

  assign tk.tick16 = tick_r;

endmodule : ssb_rate_gen

// >>> hdl/ssb_rx_sampler.sv
// Majority-vote sampler: three samples around mid-bit, noise when they disagree.
`timescale 1ns/1ps
module ssb_rx_sampler (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // Sampling control
  input  wire logic       take,
  input  wire logic       line,
  input  wire logic [1:0] idx,
  // Result
  output logic            bit_val,
  output logic            noisy
);

  logic [2:0] smp_r;

  // Capture samples 7, 8 and 9 of a bit.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      smp_r <= 3'h7;
    end else if (take) begin
      smp_r[idx] <= line;
    end
  end

  assign bit_val = (smp_r[0] & smp_r[1]) | (smp_r[1] & smp_r[2]) | (smp_r[0] & smp_r[2]);
  assign noisy   = !((smp_r == 3'h0) || (smp_r == 3'h7));

endmodule : ssb_rx_sampler

// >>> hdl/ssb_serial_top.sv
// Serial status flags, rate selection and a compact transmitter and receiver.
//
// The register addresses and the APB register port are this design's own decisions.
`timescale 1ns/1ps

// What this block does
// - Shared port pins reset as inputs with all direction bits cleared.
// - Status flags form the request inputs of the serial interrupt.
// - Transmit-empty flag is set whenever no character waits to send.
// - Status read with transmit-empty set, then data write, clears it.
// - Transmit-complete is set when idle, reads zero while sending.
// - Status read with transmit-complete set, then data write, clears it.
// - Receive-full is set once a received character is readable.
// - Status read with receive-full set, then data read, clears it.
// - Idle flag is set when the receive line is idle.
// - After clearing, idle needs line activity before it sets again.
// - Idle flag is suppressed while receiver wake-up control is one.
// - Status read with idle set, then data read, clears it.
// - Overrun is set when a character completes before the previous was read.
// - Status read with overrun set, then data read, clears it.
// - Noise is set when majority samples of a bit disagree.
// - Status read with noise set, then data read, clears it.
// - Framing error is set when stop bit is sampled as zero.
// - Status read with framing error set, then data read, clears it.
// - Prescaler divides the clock feeding the rate divider.
// - Prescaler resets to fastest rate and can be rewritten anytime.
module ssb_serial_top (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Shared port pins
  input  wire logic [5:0]  port_in,
  output logic [5:0]       port_out,
  output logic [5:0]       port_oe,
  // Interrupt request lines
  output logic [6:0]       serial_irq_req
);

  // ==========================================================================
  // Bus decode.
  logic wr_acc;
  logic rd_acc;
  logic hit;
  assign pready  = 1'b1;
  assign hit     = (paddr == ssb_pkg::ADDR_STATUS) || (paddr == ssb_pkg::ADDR_DATA) ||
                   (paddr == ssb_pkg::ADDR_RATE) || (paddr == ssb_pkg::ADDR_CTRL) ||
                   (paddr == ssb_pkg::ADDR_PORT);
  assign pslverr = psel && penable && !hit;
  assign wr_acc  = psel && penable && pwrite && hit;
  assign rd_acc  = psel && penable && !pwrite && hit;

  logic [7:0] rate_r;
  logic [7:0] ctrl_r;
  logic [5:0] dir_r;
  logic [5:0] pout_r;
  logic [7:0] tx_hold_r;
  logic       tx_full_r;
  logic [7:0] rx_data_r;
  logic       txc_r;
  logic       rxf_r;
  logic       idl_r;
  logic       ovr_r;
  logic       nse_r;
  logic       frm_r;
  logic       idle_armed_r;
  logic [6:0] seen_r;
  logic [7:0] status;

  // Rate register: written at any time, resets to the fastest prescale.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rate_r <= ssb_pkg::RATE_RESET;
    end else if (wr_acc && paddr == ssb_pkg::ADDR_RATE) begin
      rate_r <= pwdata[7:0];
    end
  end

  // Control register.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl_r <= ssb_pkg::CTRL_RESET;
    end else if (wr_acc && paddr == ssb_pkg::ADDR_CTRL) begin
      ctrl_r <= pwdata[7:0];
    end
  end

  // Port direction and output latches; pins start as inputs.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      dir_r  <= ssb_pkg::PORT_DIR_RESET;
      pout_r <= 6'h00;
    end else if (wr_acc && paddr == ssb_pkg::ADDR_PORT) begin
      dir_r  <= pwdata[13:8];
      pout_r <= pwdata[5:0];
    end
  end

  // ==========================================================================
  // Rate generator.
  ssb_tick_if tk ();
  assign tk.rate = rate_r;
  ssb_rate_gen u_rate (
    .ref_clk (ref_clk),
    .rst     (rst),
    .tk      (tk)
  );

  // ==========================================================================
  // Transmitter on pin 1.
  logic [9:0] tx_sh_r;
  logic [3:0] tx_bit_r;
  logic [3:0] tx_ph_r;
  logic       tx_busy_r;
  logic       tx_line;
  logic       tx_load;
  logic       tx_bit_end;
  logic       data_wr;
  logic       data_rd;
  logic       stat_rd;

  assign data_wr    = wr_acc && paddr == ssb_pkg::ADDR_DATA;
  assign data_rd    = rd_acc && paddr == ssb_pkg::ADDR_DATA;
  assign stat_rd    = rd_acc && paddr == ssb_pkg::ADDR_STATUS;
  assign tx_bit_end = tk.tick16 && tx_ph_r == 4'hF;
  assign tx_load    = !tx_busy_r && tx_full_r && ctrl_r[ssb_pkg::BIT_TX_EN];
  assign tx_line    = tx_busy_r ? tx_sh_r[0] : !ctrl_r[ssb_pkg::BIT_BREAK];

  // Holding buffer: write fills it, shifter load empties it.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tx_hold_r <= 8'h00;
      tx_full_r <= 1'b0;
    end else if (data_wr) begin
      tx_hold_r <= pwdata[7:0];
      tx_full_r <= 1'b1;
    end else if (tx_load) begin
      tx_full_r <= 1'b0;
    end
  end

  // Shift one start bit, eight data bits and a stop bit.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tx_sh_r   <= 10'h3FF;
      tx_bit_r  <= 4'h0;
      tx_ph_r   <= 4'h0;
      tx_busy_r <= 1'b0;
    end else if (tx_load) begin
      tx_sh_r   <= {1'b1, tx_hold_r, 1'b0};
      tx_bit_r  <= 4'h0;
      tx_ph_r   <= 4'h0;
      tx_busy_r <= 1'b1;
    end else if (tx_busy_r && tk.tick16) begin
      tx_ph_r <= tx_ph_r + 4'h1;
      if (tx_bit_end) begin
        tx_sh_r <= {1'b1, tx_sh_r[9:1]};
        if (tx_bit_r == 4'(ssb_pkg::FRAME_BITS - 1)) begin
          tx_busy_r <= 1'b0;
        end
        tx_bit_r <= tx_bit_r + 4'h1;
      end
    end
  end

  // Transmit-complete follows transmitter idle but stays clear after a
  // qualified write until the next frame ends.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      txc_r <= 1'b1;
    end else if (tx_busy_r || tx_load || ctrl_r[ssb_pkg::BIT_BREAK]) begin
      txc_r <= 1'b0;
    end else if (data_wr && seen_r[5] && !tx_busy_r) begin
      txc_r <= 1'b0;
    end else if (!tx_full_r) begin
      txc_r <= 1'b1;
    end
  end

  // ==========================================================================
  // Receiver on pin 0.
  logic [3:0] rx_ph_r;
  logic [3:0] rx_bit_r;
  logic [7:0] rx_sh_r;
  logic       rx_busy_r;
  logic       rx_noise_r;
  logic       rx_line;
  logic       smp_take;
  logic [1:0] smp_idx;
  logic       smp_bit;
  logic       smp_noisy;
  logic       rx_eval;
  logic       rx_done;
  logic [3:0] idle_cnt_r;
  logic [3:0] idle_ph_r;
  logic       line_idle;

  assign rx_line  = port_in[0];
  assign smp_take = rx_busy_r && tk.tick16 && rx_ph_r >= 4'h7 && rx_ph_r <= 4'h9;
  assign smp_idx  = 2'(rx_ph_r - 4'h7);
  assign rx_eval  = rx_busy_r && tk.tick16 && rx_ph_r == 4'hA;
  assign rx_done  = rx_eval && rx_bit_r == 4'(ssb_pkg::FRAME_BITS - 1);

  ssb_rx_sampler u_smp (
    .ref_clk (ref_clk),
    .rst     (rst),
    .take    (smp_take),
    .line    (rx_line),
    .idx     (smp_idx),
    .bit_val (smp_bit),
    .noisy   (smp_noisy)
  );

  // Frame receiver: start edge, sixteen ticks per bit, evaluate after votes.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rx_ph_r    <= 4'h0;
      rx_bit_r   <= 4'h0;
      rx_sh_r    <= 8'h00;
      rx_busy_r  <= 1'b0;
      rx_noise_r <= 1'b0;
    end else if (!rx_busy_r) begin
      if (!rx_line && ctrl_r[ssb_pkg::BIT_RX_EN]) begin
        rx_busy_r  <= 1'b1;
        rx_ph_r    <= 4'h0;
        rx_bit_r   <= 4'h0;
        rx_noise_r <= 1'b0;
      end
    end else if (tk.tick16) begin
      rx_ph_r <= rx_ph_r + 4'h1;
      if (rx_eval) begin
        rx_noise_r <= rx_noise_r | smp_noisy;
        if (rx_bit_r >= 4'h1 && rx_bit_r <= 4'h8) begin
          rx_sh_r <= {smp_bit, rx_sh_r[7:1]};
        end
        if (rx_done || (rx_bit_r == 4'h0 && smp_bit)) begin
          rx_busy_r <= 1'b0;
        end
      end
      if (rx_ph_r == 4'hF) begin
        rx_bit_r <= rx_bit_r + 4'h1;
      end
    end
  end

  // Idle detection: a full character time of marks while not receiving.
  assign line_idle = idle_cnt_r == 4'(ssb_pkg::IDLE_BITS);
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      idle_cnt_r <= 4'h0;
      idle_ph_r  <= 4'h0;
    end else if (!rx_line || rx_busy_r) begin
      idle_cnt_r <= 4'h0;
      idle_ph_r  <= 4'h0;
    end else if (tk.tick16 && !line_idle) begin
      idle_ph_r <= idle_ph_r + 4'h1;
      if (idle_ph_r == 4'hF) begin
        idle_cnt_r <= idle_cnt_r + 4'h1;
      end
    end
  end

  // ==========================================================================
  // Status flags with the read-then-access clear; set wins over clear for the receive and idle flags.
  logic data_clr_rd;
  assign data_clr_rd = data_rd;

  // Remember which flags a status read observed set.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      seen_r <= 7'h00;
    end else if (stat_rd) begin
      seen_r <= status[7:1];
    end else if (data_rd || data_wr) begin
      seen_r <= 7'h00;
    end
  end

  // Received data, full, overrun, noise and framing flags.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rx_data_r <= 8'h00;
      rxf_r     <= 1'b0;
      ovr_r     <= 1'b0;
      nse_r     <= 1'b0;
      frm_r     <= 1'b0;
    end else if (rx_done) begin
      if (rxf_r && !(data_clr_rd && seen_r[4])) begin
        ovr_r <= 1'b1;
      end else begin
        rx_data_r <= rx_sh_r;
        rxf_r     <= 1'b1;
        if (data_clr_rd && seen_r[2]) ovr_r <= 1'b0;
        nse_r     <= rx_noise_r | smp_noisy;
        frm_r     <= !smp_bit;
      end
    end else if (data_clr_rd) begin
      if (seen_r[4]) rxf_r <= 1'b0;
      if (seen_r[2]) ovr_r <= 1'b0;
      if (seen_r[1]) nse_r <= 1'b0;
      if (seen_r[0]) frm_r <= 1'b0;
    end
  end

  // Idle flag: rearmed only by line activity, held off by wake-up control.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      idl_r        <= 1'b0;
      idle_armed_r <= 1'b1;
    end else begin
      if (!rx_line) begin
        idle_armed_r <= 1'b1;
      end
      if (ctrl_r[ssb_pkg::BIT_WAKEUP]) begin
        idl_r <= 1'b0;
      end else if (line_idle && idle_armed_r) begin
        idl_r        <= 1'b1;
        idle_armed_r <= 1'b0;
      end else if (!line_idle) begin
        idl_r <= 1'b0;
      end else if (data_clr_rd && seen_r[3]) begin
        idl_r <= 1'b0;
      end
    end
  end

  // Status view; transmit-empty tracks the holding buffer directly.
  always_comb begin
    status = 8'h00;
    status[ssb_pkg::BIT_TXE] = !tx_full_r;
    status[ssb_pkg::BIT_TXC] = txc_r;
    status[ssb_pkg::BIT_RXF] = rxf_r;
    status[ssb_pkg::BIT_IDL] = idl_r;
    status[ssb_pkg::BIT_OVR] = ovr_r;
    status[ssb_pkg::BIT_NSE] = nse_r;
    status[ssb_pkg::BIT_FRM] = frm_r;
  end

  assign serial_irq_req = status[7:1];

  // ==========================================================================
  // Read data mux, registered during the setup phase.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      unique case (paddr)
        ssb_pkg::ADDR_STATUS: prdata <= {24'h000000, status};
        ssb_pkg::ADDR_DATA:   prdata <= {24'h000000, rx_data_r};
        ssb_pkg::ADDR_RATE:   prdata <= {24'h000000, rate_r};
        ssb_pkg::ADDR_CTRL:   prdata <= {24'h000000, ctrl_r};
        ssb_pkg::ADDR_PORT:   prdata <= {18'h00000, dir_r, 2'h0, port_in};
        default:              prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================================
  // Pin drive: the transmit line takes over pin 1 when enabled; direction rules the rest.
  always_comb begin
    port_oe  = dir_r;
    port_out = pout_r;
    if (ctrl_r[ssb_pkg::BIT_TX_EN]) begin
      port_oe[1]  = 1'b1;
      port_out[1] = tx_line;
    end
  end

endmodule : ssb_serial_top

// >>> tb/ssb_serial_props.sv
// Checker of the status flag behaviour seen at the serial block's ports.
`timescale 1ns/1ps
module ssb_serial_props (
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        rst,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  // Pins and requests
  input wire logic [5:0]  port_in,
  input wire logic [5:0]  port_out,
  input wire logic [5:0]  port_oe,
  input wire logic [6:0]  serial_irq_req
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  logic acc;
  logic data_rd;
  logic frm_seen_r;
  logic wake_r;
  logic armed_r;

  // Completed accesses.
  assign acc     = psel && penable && pready;
  assign data_rd = acc && !pwrite && paddr == ssb_pkg::ADDR_DATA;

  // Tracks a status read that saw a framing error, the wake-up bit and idle re-arming.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      frm_seen_r <= 1'b0;
      wake_r     <= 1'b0;
      armed_r    <= 1'b1;
    end else begin
      if (acc && paddr == ssb_pkg::ADDR_STATUS && !pwrite) frm_seen_r <= serial_irq_req[0];
      else if (acc && paddr == ssb_pkg::ADDR_DATA) frm_seen_r <= 1'b0;
      if (acc && pwrite && paddr == ssb_pkg::ADDR_CTRL) wake_r <= pwdata[ssb_pkg::BIT_WAKEUP];
      if (!port_in[0]) armed_r <= 1'b1;
      else if ($fell(serial_irq_req[3])) armed_r <= 1'b0;
    end
  end

  // ==========================================================================
  // Clearing sequence: status read seeing the flag, then the data access.
  sequence s_seen(int b);
    acc && !pwrite && paddr == ssb_pkg::ADDR_STATUS && serial_irq_req[b];
  endsequence
  sequence s_data(bit w);
    acc && pwrite == w && paddr == ssb_pkg::ADDR_DATA;
  endsequence
  property p_clr(int b, bit w);
    s_seen(b) ##3 s_data(w) |=> !serial_irq_req[b];
  endproperty

  AST_RESET: assert property ($fell(rst) |-> port_oe == 6'h00 && serial_irq_req == 7'h60)
    else $error("pins or flags wrong after reset");
  AST_MIRROR: assert property (psel && !penable && !pwrite && paddr == ssb_pkg::ADDR_STATUS
    |=> prdata[7:0] == {$past(serial_irq_req), 1'b0}) else $error("status differs from requests");
  AST_TXE_CLR: assert property (p_clr(6, 1'b1)) else $error("transmit empty not cleared");
  AST_TXC_CLR: assert property (p_clr(5, 1'b1)) else $error("transmit complete not cleared");
  AST_TXC_BUSY: assert property (port_oe[1] && !port_out[1] |-> !serial_irq_req[5])
    else $error("transmit complete set while sending");
  AST_RXF_CLR: assert property (p_clr(4, 1'b0)) else $error("receive full not cleared");
  AST_IDL_CLR: assert property (p_clr(3, 1'b0)) else $error("idle not cleared");
  AST_OVR_CLR: assert property (p_clr(2, 1'b0)) else $error("overrun not cleared");
  AST_NSE_CLR: assert property (p_clr(1, 1'b0)) else $error("noise not cleared");
  AST_FRM_CLR: assert property (p_clr(0, 1'b0)) else $error("framing error not cleared");
  AST_KEEP: assert property (data_rd && !frm_seen_r && serial_irq_req[0] |=> serial_irq_req[0])
    else $error("flag cleared without status read");
  AST_WAKE: assert property (wake_r ##1 wake_r |-> !$rose(serial_irq_req[3]))
    else $error("idle set during wake-up");
  AST_REARM: assert property ($rose(serial_irq_req[3]) |-> armed_r)
    else $error("idle set again without line activity");
endmodule : ssb_serial_props

bind ssb_serial_top ssb_serial_props u_props (.ref_clk, .rst, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pready, .prdata, .port_in, .port_out, .port_oe, .serial_irq_req);

// >>> tb/ssb_line_model.sv
// Remote line partner: sends frames to the receive pin, captures frames from the transmit pin.
`timescale 1ns/1ps
module ssb_line_model (
  // Clock
  input  wire logic ref_clk,
  // Line
  input  wire logic tx_line,
  input  wire logic tx_oe,
  output logic      rx_line
);
  int         bit_cyc = 16;
  int         n_got   = 0;
  logic [7:0] got;

  initial rx_line = 1'b1;

  // Sends one frame LSB first, with a chosen stop level and a one-cycle glitch.
  task automatic send(input logic [7:0] b, input logic stp, input int g);
    logic [9:0] f;
    f = {stp, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      for (int c = 0; c < bit_cyc; c++) begin
        @(posedge ref_clk);
        rx_line <= (i == g && c == 9) ? ~f[i] : f[i];
      end
    end
    @(posedge ref_clk);
    rx_line <= 1'b1;
  endtask : send

  // Captures frames on the driven transmit pin, sampling mid-bit.
  always begin
    @(posedge ref_clk);
    if (tx_oe === 1'b1 && tx_line === 1'b0) begin
      repeat (bit_cyc / 2) @(posedge ref_clk);
      for (int i = 0; i < 8; i++) begin
        repeat (bit_cyc) @(posedge ref_clk);
        got[i] = tx_line;
      end
      repeat (bit_cyc) @(posedge ref_clk);
      n_got++;
    end
  end
endmodule : ssb_line_model

// >>> tb/ssb_serial_top_bench.sv
// Bench driving the serial block over APB against the remote line model.
`timescale 1ns/1ps
`define CHK(nm, e, a) begin n_tests++; if ((a) !== (e)) begin n_mismatch++; \
  $display("wrong value %s: expected %h, seen %h", nm, e, a); end end
module ssb_serial_top_bench;
  logic        ref_clk = 1'b0;
  logic        rst     = 1'b1;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h00000000;
  logic        pready, pslverr, rx_line, err;
  logic [31:0] prdata, q;
  logic [5:0]  port_out, port_oe;
  logic [6:0]  serial_irq_req;
  int          n_mismatch = 0;
  int          n_tests    = 0;
  int          cyc        = 0;
  logic [7:0]  rates[5] = '{8'h01, 8'h10, 8'h23, 8'h30, 8'h40};
  int          cycs[5]  = '{32, 48, 512, 208, 256};

  always #5 ref_clk = ~ref_clk;

  ssb_serial_top i_dut (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .port_in({5'h0A, rx_line}), .port_out(port_out), .port_oe(port_oe),
    .serial_irq_req(serial_irq_req));
  ssb_line_model u_line (.ref_clk(ref_clk), .tx_line(port_out[1]), .tx_oe(port_oe[1]),
    .rx_line(rx_line));

  // ==========================================================================
  // APB master: setup, access until ready, then release.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h000000, d});
  endtask : wr
  task automatic stat();
    apb(1'b0, ssb_pkg::ADDR_STATUS, 32'h00000000);
  endtask : stat
  task automatic drd();
    apb(1'b0, ssb_pkg::ADDR_DATA, 32'h00000000);
  endtask : drd
  task automatic idle_wait();
    repeat (ssb_pkg::IDLE_BITS * 16 + 40) @(posedge ref_clk);
  endtask : idle_wait

  // Receives one frame, checks flags and data, then the clearing sequence.
  task automatic rx_case(input logic [7:0] b, input logic stp, input int g, input logic [4:0] ef);
    u_line.send(b, stp, g);
    repeat (4) @(posedge ref_clk);
    stat();
    `CHK("rx flags", ef, q[5:1])
    drd();
    `CHK("rx data", b, q[7:0])
    stat();
    `CHK("rx cleared", 5'h00, q[5:1])
  endtask : rx_case

  // Prints the verdict and ends the run.
  task automatic end_of_test();
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_of_test

  // Cuts a hung run short.
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  // Main sequence.
  initial begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    `CHK("port_oe", 6'h00, port_oe)
    `CHK("irq", 7'h60, serial_irq_req)
    stat();
    `CHK("status", 8'hC0, q[7:0])
    apb(1'b0, ssb_pkg::ADDR_RATE, 32'h00000000);
    `CHK("rate", ssb_pkg::RATE_RESET, q[7:0])
    apb(1'b0, ssb_pkg::ADDR_PORT, 32'h00000000);
    `CHK("port", 32'h00000015, q)
    apb(1'b1, ssb_pkg::ADDR_PORT, 32'h00002A17);
    @(posedge ref_clk);
    `CHK("pins", 12'hA97, {port_oe, port_out})
    apb(1'b1, ssb_pkg::ADDR_PORT, 32'h00000000);
    apb(1'b0, 12'h020, 32'h00000000);
    `CHK("unmapped", 33'h100000000, {err, q})
    wr(ssb_pkg::ADDR_CTRL, 8'h02);
    idle_wait();
    stat();
    `CHK("idle", 1'b1, q[ssb_pkg::BIT_IDL])
    drd();
    idle_wait();
    stat();
    `CHK("idle", 1'b0, q[ssb_pkg::BIT_IDL])
    rx_case(8'hA5, 1'b1, 99, 5'b10000);
    rx_case(8'h96, 1'b1, 2, 5'b10010);
    rx_case(8'h3E, 1'b0, 99, 5'b10001);
    // Two characters without a read in between.
    u_line.send(8'h11, 1'b1, 99);
    u_line.send(8'h22, 1'b1, 99);
    repeat (4) @(posedge ref_clk);
    stat();
    `CHK("overrun", 5'b10100, q[5:1])
    drd();
    stat();
    `CHK("overrun", 5'h00, q[5:1])
    // Data read with no status read first leaves the flags alone.
    u_line.send(8'h5A, 1'b0, 99);
    repeat (4) @(posedge ref_clk);
    drd();
    stat();
    `CHK("kept", 5'b10001, q[5:1])
    drd();
    wr(ssb_pkg::ADDR_CTRL, 8'h06);
    idle_wait();
    stat();
    `CHK("wake idle", 1'b0, q[ssb_pkg::BIT_IDL])
    wr(ssb_pkg::ADDR_CTRL, 8'h02);
    idle_wait();
    stat();
    `CHK("idle", 1'b1, q[ssb_pkg::BIT_IDL])
    drd();
    // Transmit one character and watch the transmit flags.
    wr(ssb_pkg::ADDR_CTRL, 8'h03);
    stat();
    `CHK("tx flags", 2'b11, q[7:6])
    wr(ssb_pkg::ADDR_DATA, 8'h3C);
    `CHK("tx oe", 1'b1, port_oe[1])
    stat();
    `CHK("tx busy", 1'b0, q[ssb_pkg::BIT_TXC])
    while (u_line.n_got == 0) @(posedge ref_clk);
    `CHK("tx data", 8'h3C, u_line.got)
    repeat (20) @(posedge ref_clk);
    stat();
    `CHK("tx idle", 2'b11, q[7:6])
    // Every prescaler setting with a divider; low bits zero with the high bit.
    for (int i = 0; i < 5; i++) begin
      wr(ssb_pkg::ADDR_RATE, rates[i]);
      u_line.bit_cyc = cycs[i];
      rx_case(8'hC3 ^ rates[i], 1'b1, 99, 5'b10000);
    end
    end_of_test();
  end
endmodule : ssb_serial_top_bench
